// ===== fqt_regs.vh
// Constants for the flash extended query table block
// How it works
// - The three signature bytes 50h, 52h, 49h sit at the table base and the next two addresses.
// - The major version reads ASCII 31h and the minor version ASCII 34h right after the signature.
// - The 32-bit feature word is low byte first, reserved bits 11 to 29 are zero, bytes E6h, 01h.
// - Bit 31 of the feature word flags a further feature field; the host parses it only when set.
// - Feature bits show suspends, instant locking, protection, page and sync read only.
// - The fourth feature byte reads 40h on the first die of a stacked pair, else 00h.
// - The suspend functions byte reads 01h: program allowed during erase suspend.
// - The block status mask reads 03h then 00h: lock and lock-down status only.
// - The logic supply program voltage reads 18h in BCD volts and tenths.
// - The program supply voltage reads 90h, volts in hex and tenths in BCD.
// - The protection field count reads 02h; the host takes zero as 256 fields.
// - The first protection descriptor reads 80h, 00h, 03h, 03h.
// - The second descriptor reads 89h, zeros, user groups 10h and log2 group size 04h.
`ifndef FQT_REGS_VH
`define FQT_REGS_VH

// Bus widths
`define FQT_AW           12
`define FQT_IW           10

// Word indexes; byte address is four times the index
`define FQT_IDX_CTRL     10'h000
`define FQT_IDX_STAT     10'h001
`define FQT_IDX_FIRST    10'h10a
`define FQT_IDX_SIG0     10'h10a
`define FQT_IDX_SIG1     10'h10b
`define FQT_IDX_SIG2     10'h10c
`define FQT_IDX_MAJ      10'h10d
`define FQT_IDX_MIN      10'h10e
`define FQT_IDX_FEAT0    10'h10f
`define FQT_IDX_FEAT1    10'h110
`define FQT_IDX_FEAT2    10'h111
`define FQT_IDX_FEAT3    10'h112
`define FQT_IDX_SUSP     10'h113
`define FQT_IDX_BSM0     10'h114
`define FQT_IDX_BSM1     10'h115
`define FQT_IDX_VLOG     10'h116
`define FQT_IDX_VPROG    10'h117
`define FQT_IDX_PCNT     10'h118
`define FQT_IDX_PD1_0    10'h119
`define FQT_IDX_PD1_2    10'h11b
`define FQT_IDX_PD1_3    10'h11c
`define FQT_IDX_PD2_0    10'h11d
`define FQT_IDX_PD2_7    10'h124
`define FQT_IDX_PD2_9    10'h126
`define FQT_IDX_LAST     10'h126

// Table contents
`define FQT_V_SIG0       8'h50
`define FQT_V_SIG1       8'h52
`define FQT_V_SIG2       8'h49
`define FQT_V_MAJ        8'h31
`define FQT_V_MIN        8'h34
`define FQT_V_FEAT0      8'he6
`define FQT_V_FEAT1      8'h01
`define FQT_V_LINK       8'h40
`define FQT_V_SUSP       8'h01
`define FQT_V_BSM0       8'h03
`define FQT_V_VLOG       8'h18
`define FQT_V_VPROG      8'h90
`define FQT_V_PCNT       8'h02
`define FQT_V_PD1_0      8'h80
`define FQT_V_PD1_LOG    8'h03
`define FQT_V_PD2_0      8'h89
`define FQT_V_PD2_UGRP   8'h10
`define FQT_V_PD2_ULOG   8'h04
`define FQT_V_ZERO       8'h00

// Control and status fields
`define FQT_CTRL_STRICT  0
`define FQT_STAT_LINK    0
`define FQT_STAT_STACK   1
`define FQT_STAT_SECOND  2
`define FQT_STAT_CNT_LO  8
`define FQT_STAT_CNT_HI  15

// Answers
`define FQT_RESP_OKAY    2'h0
`define FQT_RESP_SLVERR  2'h2
`define FQT_RESP_DECERR  2'h3

`endif

// ===== fqt_query_table.v
// Flash extended query table behind an AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fqt_regs.vh"

module fqt_query_table (
   input  wire                mclk_in,
   input  wire                rst_in,
   // Die position straps from pins
   input  wire                stacked_pair_in,
   input  wire                second_die_in,
   // Write address channel
   input  wire                s_axi_awvalid_in,
   output wire                s_axi_awready_out,
   input  wire [`FQT_AW-1:0]  s_axi_awaddr_in,
   input  wire [2:0]          s_axi_awprot_in,
   // Write data channel
   input  wire                s_axi_wvalid_in,
   output wire                s_axi_wready_out,
   input  wire [31:0]         s_axi_wdata_in,
   input  wire [3:0]          s_axi_wstrb_in,
   // Write response channel
   output wire                s_axi_bvalid_out,
   input  wire                s_axi_bready_in,
   output wire [1:0]          s_axi_bresp_out,
   // Read address channel
   input  wire                s_axi_arvalid_in,
   output wire                s_axi_arready_out,
   input  wire [`FQT_AW-1:0]  s_axi_araddr_in,
   input  wire [2:0]          s_axi_arprot_in,
   // Read data channel
   output wire                s_axi_rvalid_out,
   input  wire                s_axi_rready_in,
   output wire [31:0]         s_axi_rdata_out,
   output wire [1:0]          s_axi_rresp_out
);

   // Fixed byte at a table index; link byte comes from die position
   function [7:0] fqt_byte;
      input [`FQT_IW-1:0] idx;
      input               link;
      begin
         case (idx)
            `FQT_IDX_SIG0:  fqt_byte = `FQT_V_SIG0;
            `FQT_IDX_SIG1:  fqt_byte = `FQT_V_SIG1;
            `FQT_IDX_SIG2:  fqt_byte = `FQT_V_SIG2;
            `FQT_IDX_MAJ:   fqt_byte = `FQT_V_MAJ;
            `FQT_IDX_MIN:   fqt_byte = `FQT_V_MIN;
            `FQT_IDX_FEAT0: fqt_byte = `FQT_V_FEAT0;
            `FQT_IDX_FEAT1: fqt_byte = `FQT_V_FEAT1;
            `FQT_IDX_FEAT2: fqt_byte = `FQT_V_ZERO;
            // Top bit stays clear: no further feature field follows
            `FQT_IDX_FEAT3: fqt_byte = link ? `FQT_V_LINK : `FQT_V_ZERO;
            `FQT_IDX_SUSP:  fqt_byte = `FQT_V_SUSP;
            `FQT_IDX_BSM0:  fqt_byte = `FQT_V_BSM0;
            `FQT_IDX_BSM1:  fqt_byte = `FQT_V_ZERO;
            `FQT_IDX_VLOG:  fqt_byte = `FQT_V_VLOG;
            `FQT_IDX_VPROG: fqt_byte = `FQT_V_VPROG;
            `FQT_IDX_PCNT:  fqt_byte = `FQT_V_PCNT;
            `FQT_IDX_PD1_0: fqt_byte = `FQT_V_PD1_0;
            `FQT_IDX_PD1_2: fqt_byte = `FQT_V_PD1_LOG;
            `FQT_IDX_PD1_3: fqt_byte = `FQT_V_PD1_LOG;
            `FQT_IDX_PD2_0: fqt_byte = `FQT_V_PD2_0;
            `FQT_IDX_PD2_7: fqt_byte = `FQT_V_PD2_UGRP;
            `FQT_IDX_PD2_9: fqt_byte = `FQT_V_PD2_ULOG;
            // Remaining table bytes are zero
            default:        fqt_byte = `FQT_V_ZERO;
         endcase
      end
   endfunction

   // True when an index falls inside the query table
   function in_table;
      input [`FQT_IW-1:0] idx;
      begin
         in_table = (idx >= `FQT_IDX_FIRST) && (idx <= `FQT_IDX_LAST);
      end
   endfunction

   // True when an index names a block register or table byte
   function is_mapped;
      input [`FQT_IW-1:0] idx;
      begin
         is_mapped = in_table(idx) || (idx == `FQT_IDX_CTRL) ||
                     (idx == `FQT_IDX_STAT);
      end
   endfunction

   // Strap synchronisers
   reg        stack_meta_reg;
   reg        stack_sync_reg;
   reg        second_meta_reg;
   reg        second_sync_reg;

   // Die position held from reset
   reg        stack_cfg_reg;
   reg        second_cfg_reg;

   // Control and status state
   reg        strict_reg;
   reg        strict_next;
   reg  [7:0] refused_cnt_reg;
   reg  [7:0] refused_cnt_next;

   // Write channel state
   reg                aw_held_reg;
   reg  [`FQT_IW-1:0] aw_idx_reg;
   reg                w_held_reg;
   reg  [31:0]        w_data_reg;
   reg  [3:0]         w_strb_reg;
   reg                bvalid_reg;
   reg  [1:0]         bresp_reg;
   reg  [1:0]         bresp_next;

   // Read channel state
   reg                rvalid_reg;
   reg  [31:0]        rdata_reg;
   reg  [31:0]        rdata_next;
   reg  [1:0]         rresp_reg;
   reg  [1:0]         rresp_next;

   wire               link_byte;
   wire               aw_take;
   wire               w_take;
   wire               ar_take;
   wire               wr_go;
   wire [`FQT_IW-1:0] ar_idx;
   wire [31:0]        status_word;

   // Pin straps pass two flip-flops
   always @(posedge mclk_in) begin
      stack_meta_reg  <= stacked_pair_in;
      stack_sync_reg  <= stack_meta_reg;
      second_meta_reg <= second_die_in;
      second_sync_reg <= second_meta_reg;
   end

   // Die position follows the straps only while reset is held
   always @(posedge mclk_in) begin
      if (rst_in) begin
         stack_cfg_reg  <= stack_sync_reg;
         second_cfg_reg <= second_sync_reg;
      end
   end

   // Link byte set only on the first die of a stacked pair
   assign link_byte = stack_cfg_reg & ~second_cfg_reg;

   // Status word shows die position and the count of writes to table bytes
   assign status_word = {16'h0000, refused_cnt_reg, 5'h00, second_cfg_reg,
                         stack_cfg_reg, link_byte};

   // Handshakes; each channel idles once its item is held
   assign aw_take = s_axi_awvalid_in & s_axi_awready_out;
   assign w_take  = s_axi_wvalid_in & s_axi_wready_out;
   assign ar_take = s_axi_arvalid_in & s_axi_arready_out;
   assign wr_go   = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign ar_idx  = s_axi_araddr_in[`FQT_AW-1:2];

   assign s_axi_awready_out = ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready_out  = ~w_held_reg & ~bvalid_reg;
   assign s_axi_arready_out = ~rvalid_reg;

   // Answers come from flip-flops
   assign s_axi_bvalid_out = bvalid_reg;
   assign s_axi_bresp_out  = bresp_reg;
   assign s_axi_rvalid_out = rvalid_reg;
   assign s_axi_rdata_out  = rdata_reg;
   assign s_axi_rresp_out  = rresp_reg;

   // Write decode; table bytes never change
   always @* begin
      strict_next      = strict_reg;
      refused_cnt_next = refused_cnt_reg;
      bresp_next       = bresp_reg;
      if (wr_go) begin
         if (aw_idx_reg == `FQT_IDX_CTRL) begin
            bresp_next = `FQT_RESP_OKAY;
            if (w_strb_reg[0]) begin
               strict_next = w_data_reg[`FQT_CTRL_STRICT];
            end
         end else if (in_table(aw_idx_reg)) begin
            // Write dropped; value kept, attempt counted
            refused_cnt_next = refused_cnt_reg + 8'h01;
            bresp_next = strict_reg ? `FQT_RESP_SLVERR : `FQT_RESP_OKAY;
         end else if (aw_idx_reg == `FQT_IDX_STAT) begin
            bresp_next = strict_reg ? `FQT_RESP_SLVERR : `FQT_RESP_OKAY;
         end else begin
            bresp_next = `FQT_RESP_DECERR;
         end
      end
   end

   // Write address and data taken in either order
   always @(posedge mclk_in) begin
      if (rst_in) begin
         aw_held_reg <= 1'b0;
         aw_idx_reg  <= {`FQT_IW{1'b0}};
         w_held_reg  <= 1'b0;
         w_data_reg  <= 32'h00000000;
         w_strb_reg  <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr_in[`FQT_AW-1:2];
         end else if (wr_go) begin
            aw_held_reg <= 1'b0;
         end
         if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata_in;
            w_strb_reg <= s_axi_wstrb_in;
         end else if (wr_go) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // Write response and control state
   always @(posedge mclk_in) begin
      if (rst_in) begin
         bvalid_reg      <= 1'b0;
         bresp_reg       <= `FQT_RESP_OKAY;
         strict_reg      <= 1'b0;
         refused_cnt_reg <= 8'h00;
      end else begin
         strict_reg      <= strict_next;
         refused_cnt_reg <= refused_cnt_next;
         bresp_reg       <= bresp_next;
         if (wr_go) begin
            bvalid_reg <= 1'b1;
         end else if (s_axi_bready_in) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Read decode
   always @* begin
      rdata_next = 32'h00000000;
      rresp_next = `FQT_RESP_OKAY;
      if (!is_mapped(ar_idx)) begin
         rresp_next = `FQT_RESP_DECERR;
      end else if (ar_idx == `FQT_IDX_CTRL) begin
         rdata_next[`FQT_CTRL_STRICT] = strict_reg;
      end else if (ar_idx == `FQT_IDX_STAT) begin
         rdata_next = status_word;
      end else begin
         // One query byte per word, upper bits zero
         rdata_next[7:0] = fqt_byte(ar_idx, link_byte);
      end
   end

   // Read response held until taken
   always @(posedge mclk_in) begin
      if (rst_in) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h00000000;
         rresp_reg  <= `FQT_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rdata_next;
         rresp_reg  <= rresp_next;
      end else if (s_axi_rready_in) begin
         rvalid_reg <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// ===== fqt_query_table_sva.sv
// Assertions on the query table slave ports
`timescale 1ns/1ps
`default_nettype none
`include "fqt_regs.vh"
module fqt_query_table_sva (
   input wire logic               mclk_in,
   input wire logic               rst_in,
   input wire logic               s_axi_awvalid_in,
   input wire logic               s_axi_awready_out,
   input wire logic               s_axi_wvalid_in,
   input wire logic               s_axi_wready_out,
   input wire logic               s_axi_bvalid_out,
   input wire logic               s_axi_bready_in,
   input wire logic               s_axi_arvalid_in,
   input wire logic               s_axi_arready_out,
   input wire logic [`FQT_AW-1:0] s_axi_araddr_in,
   input wire logic               s_axi_rvalid_out,
   input wire logic               s_axi_rready_in,
   input wire logic [31:0]        s_axi_rdata_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   // Handshakes and word index of a read
   wire       ar_go  = s_axi_arvalid_in & s_axi_arready_out;
   wire       wr_go  = s_axi_awvalid_in & s_axi_awready_out & s_axi_wvalid_in & s_axi_wready_out;
   wire [9:0] ar_idx = s_axi_araddr_in[11:2];
   a_read_answer: assert property (ar_go |=> s_axi_rvalid_out)
      else $error("read answer late");
   a_read_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
   a_ar_blocked: assert property (s_axi_arready_out == !s_axi_rvalid_out)
      else $error("read accept wrong");
   a_sig_first: assert property (ar_go && ar_idx == `FQT_IDX_SIG0 |=>
      s_axi_rdata_out == 32'h0000_0050) else $error("signature byte wrong");
   a_feat_low: assert property (ar_go && ar_idx == `FQT_IDX_FEAT0 |=>
      s_axi_rdata_out == 32'h0000_00e6) else $error("feature byte wrong");
   a_vprog_code: assert property (ar_go && ar_idx == `FQT_IDX_VPROG |=>
      s_axi_rdata_out == 32'h0000_0090) else $error("supply code wrong");
   a_write_answer: assert property (wr_go |=> ##1 s_axi_bvalid_out)
      else $error("write answer late");
   a_write_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out) else $error("write answer dropped");
   a_write_blocked: assert property (s_axi_bvalid_out |->
      !s_axi_awready_out && !s_axi_wready_out) else $error("write accepted early");
endmodule
`default_nettype wire

// ===== fqt_host_model.sv
// Host controller model reading the query table over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module fqt_host_model (
   input  wire logic        clk_in,
   output logic             awv_out,
   output logic [11:0]      awa_out,
   output logic             wv_out,
   output logic [31:0]      wd_out,
   output logic             br_out,
   output logic             arv_out,
   output logic [11:0]      ara_out,
   output logic             rr_out,
   input  wire logic        awr_in,
   input  wire logic        wr_in,
   input  wire logic        bv_in,
   input  wire logic [1:0]  bresp_in,
   input  wire logic        arr_in,
   input  wire logic        rv_in,
   input  wire logic [31:0] rd_in,
   input  wire logic [1:0]  rresp_in
);
   // Bus idle from time zero
   initial {awv_out, awa_out, wv_out, wd_out, br_out, arv_out, ara_out, rr_out} = '0;
   // A zero count means the full 256 fields
   function automatic int field_count(input logic [7:0] c);
      return (c == 8'h00) ? 256 : int'(c);
   endfunction
   // Further feature field only parsed when flagged
   function automatic logic more_fields(input logic [31:0] f);
      return f[31];
   endfunction
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge clk_in);
      {awa_out, wd_out, awv_out, wv_out, br_out} <= {a, d, 3'b111};
      while (!done) begin
         @(posedge clk_in);
         if (awr_in) awv_out <= 1'b0;
         if (wr_in) wv_out <= 1'b0;
         if (bv_in) begin
            r = bresp_in;
            br_out <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
   // Read: address held until taken, data taken with rvalid
   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge clk_in);
      {ara_out, arv_out, rr_out} <= {a, 2'b11};
      while (!done) begin
         @(posedge clk_in);
         if (arr_in) arv_out <= 1'b0;
         if (rv_in) begin
            {d, r} = {rd_in, rresp_in};
            rr_out <= 1'b0;
            done = 1'b1;
         end
      end
   endtask
endmodule
`default_nettype wire

// ===== fqt_query_table_tb_top.sv
// Self-checking bench for the query table slave
`timescale 1ns/1ps
`default_nettype none
`include "fqt_regs.vh"
module fqt_query_table_tb_top;
   logic        mclk, rst, stk, sec, awv, wv, br, arv, rr, awr, wr, bv, arr, rv;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdata, d;
   logic [1:0]  bresp, rresp, r;
   int          miscompares, compares;
   logic [7:0]  tbl [0:28] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h34, 8'he6, 8'h01, 8'h00, 8'h00,
      8'h01, 8'h03, 8'h00, 8'h18, 8'h90, 8'h02, 8'h80, 8'h00, 8'h03, 8'h03, 8'h89, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h04};
   // Clock and design
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;
   fqt_query_table fqt_query_table_inst (.mclk_in(mclk), .rst_in(rst), .stacked_pair_in(stk),
      .second_die_in(sec), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_awaddr_in(awa), .s_axi_awprot_in(3'h0), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bv), .s_axi_bready_in(br),
      .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
      .s_axi_araddr_in(ara), .s_axi_arprot_in(3'h0), .s_axi_rvalid_out(rv),
      .s_axi_rready_in(rr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp));
   fqt_host_model fqt_host_model_inst (.clk_in(mclk), .awv_out(awv), .awa_out(awa), .wv_out(wv),
      .wd_out(wd), .br_out(br), .arv_out(arv), .ara_out(ara), .rr_out(rr), .awr_in(awr),
      .wr_in(wr), .bv_in(bv), .bresp_in(bresp), .arr_in(arr), .rv_in(rv), .rd_in(rdata),
      .rresp_in(rresp));
   // Compare and count
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         miscompares++;
         $display("BAD t=%0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      fqt_host_model_inst.rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
   endtask
   task automatic wchk(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
      fqt_host_model_inst.wr(a, v, r);
      chk({30'h0, r}, {30'h0, er});
   endtask
   // Whole table in ascending order, link byte per die
   task automatic sweep(input logic lk);
      for (int i = 0; i < 29; i++)
         rchk(12'h428 + 12'(i * 4), {24'h0, (i == 8 && lk) ? 8'h40 : tbl[i]}, 2'h0);
   endtask
   task automatic do_reset(input logic s2);
      rst <= 1'b1;
      sec <= s2;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("TB: compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Tests
   initial begin
      {rst, stk, sec} = 3'b110;
      do_reset(1'b0);
      sweep(1'b1);
      rchk(12'h448, 32'h0000_0040, `FQT_RESP_OKAY);
      chk({31'h0, fqt_host_model_inst.more_fields({d[7:0], 24'h0})}, 32'h0);
      rchk(12'h460, 32'h0000_0002, `FQT_RESP_OKAY);
      chk(fqt_host_model_inst.field_count(d[7:0]), 32'd2);
      chk(fqt_host_model_inst.field_count(8'h00), 32'd256);
      $display("TB: first die table done");
      wchk(12'h428, 32'h0000_00ff, `FQT_RESP_OKAY);
      wchk(12'h490, 32'h0000_0000, `FQT_RESP_OKAY);
      rchk(12'h428, 32'h0000_0050, `FQT_RESP_OKAY);
      rchk(12'h490, 32'h0000_0010, `FQT_RESP_OKAY);
      wchk(12'h000, 32'h0000_0001, `FQT_RESP_OKAY);
      wchk(12'h43c, 32'h0000_0000, `FQT_RESP_SLVERR);
      rchk(12'h43c, 32'h0000_00e6, `FQT_RESP_OKAY);
      rchk(12'h004, 32'h0000_0303, `FQT_RESP_OKAY);
      rchk(12'h800, 32'h0000_0000, `FQT_RESP_DECERR);
      wchk(12'h800, 32'h0000_0001, `FQT_RESP_DECERR);
      $display("TB: write refusal done");
      do_reset(1'b1);
      sweep(1'b0);
      rchk(12'h004, 32'h0000_0006, `FQT_RESP_OKAY);
      $display("TB: second die table done");
      end_of_test;
   end
   // Watchdog well past the expected run
   initial begin
      repeat (3000) @(posedge mclk);
      miscompares++;
      end_of_test;
   end
endmodule
bind fqt_query_table fqt_query_table_sva fqt_query_table_sva_inst (.mclk_in(mclk_in),
   .rst_in(rst_in), .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
   .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
   .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
   .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
   .s_axi_araddr_in(s_axi_araddr_in), .s_axi_rvalid_out(s_axi_rvalid_out),
   .s_axi_rready_in(s_axi_rready_in), .s_axi_rdata_out(s_axi_rdata_out));
`default_nettype wire
